// ==== hw/sdc_pkg.sv ====
package sdc_pkg;

    // ***************************************************
    // register select codes
    // ***************************************************
    localparam logic [1:0] RS_COMMS = 2'h0;
    localparam logic [1:0] RS_SETUP = 2'h1;
    localparam logic [1:0] RS_TEST  = 2'h2;
    localparam logic [1:0] RS_DATA  = 2'h3;

    // ***************************************************
    // conversion setup register layout
    // ***************************************************
    localparam logic [7:0] SETUP_RESET   = 8'h28;
    localparam int         MODE_HI_POS   = 7;
    localparam int         MODE_LO_POS   = 6;
    localparam int         CLK_RANGE_POS = 5;
    localparam int         RATE_HI_POS   = 4;
    localparam int         RATE_LO_POS   = 3;
    localparam int         POLARITY_POS  = 2;
    localparam int         BUFFER_POS    = 1;
    localparam int         HOLD_POS      = 0;

    localparam logic [1:0] MODE_NORMAL   = 2'h0;
    localparam logic [1:0] MODE_SELF_CAL = 2'h1;
    localparam logic [1:0] MODE_ZERO_CAL = 2'h2;
    localparam logic [1:0] MODE_FULL_CAL = 2'h3;

    // ***************************************************
    // serial port framing
    // ***************************************************
    localparam int         BYTE_BITS     = 8;
    localparam int         DATA_BITS     = 16;
    localparam int         RESYNC_ONES   = 32;

    // ***************************************************
    // update rates in Hz and filter timing
    // ***************************************************
    localparam logic [9:0] RATE_SLOW_0   = 10'd20;
    localparam logic [9:0] RATE_SLOW_1   = 10'd25;
    localparam logic [9:0] RATE_SLOW_2   = 10'd100;
    localparam logic [9:0] RATE_SLOW_3   = 10'd200;
    localparam logic [9:0] RATE_FAST_0   = 10'd50;
    localparam logic [9:0] RATE_FAST_1   = 10'd60;
    localparam logic [9:0] RATE_FAST_2   = 10'd250;
    localparam logic [9:0] RATE_FAST_3   = 10'd500;
    localparam logic [2:0] HOLD_SETTLE_WORDS = 3'd3;
    localparam logic [2:0] STEP_SETTLE_WORDS = 3'd4;
    localparam logic [8:0] CUTOFF_PER_MILLE  = 9'd262;

    function automatic logic [9:0] rate_hz(input logic [2:0] sel);
        unique case (sel)
            3'h0: rate_hz = RATE_SLOW_0;
            3'h1: rate_hz = RATE_SLOW_1;
            3'h2: rate_hz = RATE_SLOW_2;
            3'h3: rate_hz = RATE_SLOW_3;
            3'h4: rate_hz = RATE_FAST_0;
            3'h5: rate_hz = RATE_FAST_1;
            3'h6: rate_hz = RATE_FAST_2;
            3'h7: rate_hz = RATE_FAST_3;
        endcase
    endfunction : rate_hz

endpackage : sdc_pkg

// ==== hw/sdc_serial_port.sv ====
`timescale 1ns/1ps

module sdc_serial_port (
    input  wire logic        core_clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        sclk_i,
    input  wire logic        din_i,
    input  wire logic        cs_n_i,
    input  wire logic [7:0]  setup_rd_i,
    input  wire logic [15:0] data_rd_i,
    input  wire logic        ready_n_i,
    output logic             dout_o,
    output logic             setup_wr_o,
    output logic [7:0]       setup_wdata_o,
    output logic             data_read_o,
    output logic             standby_o,
    output logic [1:0]       gain_o
);

    typedef enum logic {PH_COMMS, PH_ACCESS} sdc_phase_t;

    // ***************************************************
    // pin synchronisers, a change counts once stages agree
    // ***************************************************
    logic [2:0]  sclk_sy_q;
    logic [2:0]  din_sy_q;
    logic [2:0]  csn_sy_q;
    logic        sclk_f_q;
    logic        din_f_q;
    logic        csn_f_q;

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            sclk_sy_q <= 3'h7;
            din_sy_q  <= 3'h0;
            csn_sy_q  <= 3'h7;
            sclk_f_q  <= 1'b1;
            din_f_q   <= 1'b0;
            csn_f_q   <= 1'b1;
        end else begin
            sclk_sy_q <= {sclk_sy_q[1:0], sclk_i};
            din_sy_q  <= {din_sy_q[1:0], din_i};
            csn_sy_q  <= {csn_sy_q[1:0], cs_n_i};
            if (sclk_sy_q[1] == sclk_sy_q[2]) sclk_f_q <= sclk_sy_q[2];
            if (din_sy_q[1] == din_sy_q[2]) din_f_q <= din_sy_q[2];
            if (csn_sy_q[1] == csn_sy_q[2]) csn_f_q <= csn_sy_q[2];
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    assign sclk_rise = ~csn_f_q & ~sclk_f_q & (sclk_sy_q[1] == sclk_sy_q[2]) & sclk_sy_q[2];
    assign sclk_fall = ~csn_f_q & sclk_f_q & (sclk_sy_q[1] == sclk_sy_q[2]) & ~sclk_sy_q[2];

    // ***************************************************
    // framing: command byte, then one register access
    // ***************************************************
    sdc_phase_t  phase_q;
    logic [4:0]  bitcnt_q;
    logic [5:0]  ones_q;
    logic [15:0] shin_q;
    logic [15:0] shout_q;
    logic [1:0]  rs_q;
    logic        rw_q;
    logic [7:0]  cmd_byte;
    logic [15:0] acc_word;
    logic [4:0]  acc_len;

    assign cmd_byte = {shin_q[6:0], din_f_q};
    assign acc_word = {shin_q[14:0], din_f_q};
    assign acc_len  = (rs_q == sdc_pkg::RS_DATA) ? 5'(sdc_pkg::DATA_BITS)
                                                 : 5'(sdc_pkg::BYTE_BITS);

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            phase_q       <= PH_COMMS;
            bitcnt_q      <= 5'h0;
            ones_q        <= 6'h0;
            shin_q        <= 16'h0;
            rs_q          <= 2'h0;
            rw_q          <= 1'b0;
            standby_o     <= 1'b0;
            gain_o        <= 2'h0;
            setup_wr_o    <= 1'b0;
            setup_wdata_o <= 8'h0;
            data_read_o   <= 1'b0;
        end else begin
            setup_wr_o  <= 1'b0;
            data_read_o <= 1'b0;
            if (csn_f_q) begin
                // a deselect drops only a partly shifted word
                bitcnt_q <= 5'h0;
                ones_q   <= 6'h0;
            end else if (sclk_rise) begin
                ones_q <= din_f_q ? ones_q + 6'h1 : 6'h0;
                shin_q <= acc_word;
                if (din_f_q && ones_q == 6'(sdc_pkg::RESYNC_ONES - 1)) begin
                    phase_q  <= PH_COMMS;
                    bitcnt_q <= 5'h0;
                    ones_q   <= 6'h0;
                end else if (phase_q == PH_COMMS) begin
                    if (bitcnt_q != 5'h0 || !din_f_q) begin
                        bitcnt_q <= bitcnt_q + 5'h1;
                    end
                    if (bitcnt_q == 5'(sdc_pkg::BYTE_BITS - 1)) begin
                        rs_q      <= cmd_byte[5:4];
                        rw_q      <= cmd_byte[3];
                        standby_o <= cmd_byte[2];
                        gain_o    <= cmd_byte[1:0];
                        bitcnt_q  <= 5'h0;
                        phase_q   <= PH_ACCESS;
                    end
                end else begin
                    bitcnt_q <= bitcnt_q + 5'h1;
                    if (bitcnt_q == acc_len - 5'h1) begin
                        bitcnt_q <= 5'h0;
                        phase_q  <= PH_COMMS;
                        if (!rw_q && rs_q == sdc_pkg::RS_SETUP) begin
                            setup_wr_o    <= 1'b1;
                            setup_wdata_o <= acc_word[7:0];
                        end
                        if (rw_q && rs_q == sdc_pkg::RS_DATA) data_read_o <= 1'b1;
                    end
                end
            end
        end
    end

    // ***************************************************
    // read data, msb first, moved on falling sclk
    // ***************************************************
    logic load_rd;
    assign load_rd = sclk_rise && phase_q == PH_COMMS && bitcnt_q == 5'(sdc_pkg::BYTE_BITS - 1)
                     && cmd_byte[3];

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            shout_q <= 16'h0;
            dout_o  <= 1'b0;
        end else if (load_rd) begin
            unique case (cmd_byte[5:4])
                sdc_pkg::RS_COMMS: shout_q <= {ready_n_i, 1'b0, rs_q, rw_q, standby_o,
                                               gain_o, 8'h0};
                sdc_pkg::RS_SETUP: shout_q <= {setup_rd_i, 8'h0};
                sdc_pkg::RS_TEST:  shout_q <= 16'h0;
                sdc_pkg::RS_DATA:  shout_q <= data_rd_i;
            endcase
        end else if (sclk_fall && phase_q == PH_ACCESS && rw_q) begin
            dout_o  <= shout_q[15];
            shout_q <= {shout_q[14:0], 1'b0};
        end
    end

endmodule : sdc_serial_port

// ==== hw/sdc_setup_control.sv ====
`timescale 1ns/1ps

module sdc_setup_control #(
    parameter int unsigned CORE_HZ        = 50_000_000,
    parameter int unsigned SELF_CAL_WORDS = 2,
    parameter int unsigned SYS_CAL_WORDS  = 1
) (
    input  wire logic        core_clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        sclk_i,
    input  wire logic        din_i,
    input  wire logic        cs_n_i,
    input  wire logic [15:0] result_word_i,
    output logic             dout_o,
    output logic             result_ready_n_o,
    output logic [1:0]       operating_mode_o,
    output logic             calibrating_o,
    output logic             clk_range_o,
    output logic [1:0]       update_rate_o,
    output logic             unipolar_o,
    output logic             buffer_en_o,
    output logic             filter_hold_o,
    output logic             word_stb_o,
    output logic             filter_settled_o,
    output logic [17:0]      cutoff_mhz_o,
    output logic             standby_o,
    output logic [1:0]       gain_o
);

    typedef enum logic {CAL_IDLE, CAL_RUN} sdc_cal_t;

    // ***************************************************
    // serial port
    // ***************************************************
    logic        setup_wr;
    logic [7:0]  setup_wdata;
    logic        data_read;
    logic [7:0]  setup_q;

    sdc_serial_port u_port (
        .core_clk_i    (core_clk_i),
        .sys_rst_i     (sys_rst_i),
        .sclk_i        (sclk_i),
        .din_i         (din_i),
        .cs_n_i        (cs_n_i),
        .setup_rd_i    (setup_q),
        .data_rd_i     (result_word_i),
        .ready_n_i     (result_ready_n_o),
        .dout_o        (dout_o),
        .setup_wr_o    (setup_wr),
        .setup_wdata_o (setup_wdata),
        .data_read_o   (data_read),
        .standby_o     (standby_o),
        .gain_o        (gain_o)
    );

    // ***************************************************
    // field views
    // ***************************************************
    logic [1:0] mode_w;
    logic [2:0] rate_sel;
    logic       hold_w;
    logic [1:0] new_mode;

    assign mode_w   = {setup_q[sdc_pkg::MODE_HI_POS], setup_q[sdc_pkg::MODE_LO_POS]};
    assign rate_sel = {setup_q[sdc_pkg::CLK_RANGE_POS], setup_q[sdc_pkg::RATE_HI_POS],
                       setup_q[sdc_pkg::RATE_LO_POS]};
    assign hold_w   = setup_q[sdc_pkg::HOLD_POS];
    assign new_mode = {setup_wdata[sdc_pkg::MODE_HI_POS], setup_wdata[sdc_pkg::MODE_LO_POS]};

    // notch period in core cycles; constant quotients keep a divider out
    function automatic logic [31:0] period_of(input logic [2:0] sel);
        unique case (sel)
            3'h0: period_of = 32'(CORE_HZ / sdc_pkg::rate_hz(3'h0));
            3'h1: period_of = 32'(CORE_HZ / sdc_pkg::rate_hz(3'h1));
            3'h2: period_of = 32'(CORE_HZ / sdc_pkg::rate_hz(3'h2));
            3'h3: period_of = 32'(CORE_HZ / sdc_pkg::rate_hz(3'h3));
            3'h4: period_of = 32'(CORE_HZ / sdc_pkg::rate_hz(3'h4));
            3'h5: period_of = 32'(CORE_HZ / sdc_pkg::rate_hz(3'h5));
            3'h6: period_of = 32'(CORE_HZ / sdc_pkg::rate_hz(3'h6));
            3'h7: period_of = 32'(CORE_HZ / sdc_pkg::rate_hz(3'h7));
        endcase
    endfunction : period_of

    // ***************************************************
    // calibration sequencer
    // ***************************************************
    sdc_cal_t    cal_q;
    logic [7:0]  cal_words_q;
    logic [7:0]  cal_need;
    logic        cal_start;
    logic        cal_done;
    logic        tick;

    assign cal_start = setup_wr && new_mode != sdc_pkg::MODE_NORMAL;
    assign cal_need  = (mode_w == sdc_pkg::MODE_SELF_CAL) ? 8'(SELF_CAL_WORDS)
                                                          : 8'(SYS_CAL_WORDS);
    assign cal_done  = cal_q == CAL_RUN && tick && cal_words_q + 8'h1 >= cal_need
                       && !setup_wr;

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            cal_q       <= CAL_IDLE;
            cal_words_q <= 8'h0;
        end else if (cal_start) begin
            cal_q       <= CAL_RUN;
            cal_words_q <= 8'h0;
        end else if (setup_wr) begin
            cal_q       <= CAL_IDLE;
            cal_words_q <= 8'h0;
        end else if (cal_done) begin
            cal_q       <= CAL_IDLE;
            cal_words_q <= 8'h0;
        end else if (cal_q == CAL_RUN && tick) begin
            cal_words_q <= cal_words_q + 8'h1;
        end
    end

    // ***************************************************
    // setup register
    // ***************************************************
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            setup_q <= sdc_pkg::SETUP_RESET;
        end else if (setup_wr) begin
            setup_q <= setup_wdata;
        end else if (cal_done) begin
            setup_q[sdc_pkg::MODE_HI_POS] <= 1'b0;
            setup_q[sdc_pkg::MODE_LO_POS] <= 1'b0;
        end
    end

    // ***************************************************
    // notch period timer
    // ***************************************************
    logic [31:0] per_cnt_q;
    logic        restart;

    // a new setup restarts the filter, so a rate change never runs
    // out a stale period
    assign restart = hold_w || setup_wr;
    assign tick    = !restart && per_cnt_q == period_of(rate_sel) - 32'h1;

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            per_cnt_q <= 32'h0;
        end else if (restart || tick) begin
            per_cnt_q <= 32'h0;
        end else begin
            per_cnt_q <= per_cnt_q + 32'h1;
        end
    end

    // ***************************************************
    // settling bookkeeping
    // ***************************************************
    logic [2:0] words_q;
    logic [2:0] valid_need_q;
    logic [2:0] settle_need_q;
    logic       new_word;

    // widened so a saturated count of seven still yields words
    assign new_word = tick && cal_q == CAL_IDLE && {1'b0, words_q} + 4'h1 >= {1'b0, valid_need_q};

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            words_q       <= 3'h0;
            valid_need_q  <= 3'h1;
            settle_need_q <= sdc_pkg::STEP_SETTLE_WORDS;
        end else if (hold_w) begin
            words_q       <= 3'h0;
            valid_need_q  <= sdc_pkg::HOLD_SETTLE_WORDS;
            settle_need_q <= sdc_pkg::HOLD_SETTLE_WORDS;
        end else if (setup_wr) begin
            words_q       <= 3'h0;
            valid_need_q  <= 3'h1;
            settle_need_q <= sdc_pkg::STEP_SETTLE_WORDS;
        end else if (tick && words_q != 3'h7) begin
            words_q <= words_q + 3'h1;
        end
    end

    // ***************************************************
    // result ready, active low
    // ***************************************************
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            result_ready_n_o <= 1'b1;
        end else if (new_word || cal_done) begin
            result_ready_n_o <= 1'b0;
        end else if (cal_start || data_read) begin
            // hold alone never raises it
            result_ready_n_o <= 1'b1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            word_stb_o       <= 1'b0;
            filter_settled_o <= 1'b0;
        end else begin
            word_stb_o       <= new_word || cal_done;
            filter_settled_o <= !hold_w && !setup_wr && words_q >= settle_need_q;
        end
    end

    // ***************************************************
    // decoded controls toward the converter
    // ***************************************************
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            operating_mode_o <= sdc_pkg::MODE_NORMAL;
            calibrating_o    <= 1'b0;
            clk_range_o      <= 1'b1;
            update_rate_o    <= 2'h1;
            unipolar_o       <= 1'b0;
            buffer_en_o      <= 1'b0;
            filter_hold_o    <= 1'b0;
            cutoff_mhz_o     <= 18'h0;
        end else begin
            operating_mode_o <= mode_w;
            calibrating_o    <= cal_q == CAL_RUN;
            clk_range_o      <= setup_q[sdc_pkg::CLK_RANGE_POS];
            update_rate_o    <= rate_sel[1:0];
            unipolar_o       <= setup_q[sdc_pkg::POLARITY_POS];
            buffer_en_o      <= setup_q[sdc_pkg::BUFFER_POS];
            filter_hold_o    <= hold_w;
            cutoff_mhz_o     <= 18'(sdc_pkg::rate_hz(rate_sel))
                                * 18'(sdc_pkg::CUTOFF_PER_MILLE);
        end
    end

endmodule : sdc_setup_control

// ==== dv/sdc_setup_control_monitor.sv ====
`timescale 1ns/1ps

module sdc_setup_control_mon (
    input  wire logic        core_clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        result_ready_n_o,
    input  wire logic [1:0]  operating_mode_o,
    input  wire logic        calibrating_o,
    input  wire logic        clk_range_o,
    input  wire logic [1:0]  update_rate_o,
    input  wire logic        unipolar_o,
    input  wire logic        buffer_en_o,
    input  wire logic        filter_hold_o,
    input  wire logic        word_stb_o,
    input  wire logic        filter_settled_o,
    input  wire logic [17:0] cutoff_mhz_o
);
    // ***************************************************
    // rate table and clocking
    // ***************************************************
    localparam int RATE_TAB [8] = '{20, 25, 100, 200, 50, 60, 250, 500};

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);

    reset_values_a:
        assert property ($past(sys_rst_i) |-> operating_mode_o == 2'h0 && clk_range_o
            && update_rate_o == 2'h1 && !unipolar_o && !buffer_en_o && !filter_hold_o
            && result_ready_n_o) else $error("outputs not at reset value");
    cutoff_value_a:
        assert property ($past(!sys_rst_i) && $stable({clk_range_o, update_rate_o})
            |-> cutoff_mhz_o == 18'(RATE_TAB[{clk_range_o, update_rate_o}] * 262))
            else $error("cutoff does not match rate");
    word_pulse_a:
        assert property (word_stb_o |=> !word_stb_o) else $error("word strobe too long");
    word_ready_a:
        assert property (word_stb_o |-> !result_ready_n_o) else $error("word without ready");
    hold_quiet_a:
        assert property (filter_hold_o |-> !word_stb_o) else $error("word during hold");
    hold_unsettled_a:
        assert property (filter_hold_o |=> !filter_settled_o) else $error("settled during hold");
    cal_ready_a:
        assert property ($rose(calibrating_o) |-> result_ready_n_o)
            else $error("ready low at calibration start");
    cal_mode_a:
        assert property (calibrating_o |-> operating_mode_o != 2'h0)
            else $error("mode normal while calibrating");
    cal_done_a:
        assert property ($fell(calibrating_o) |-> ##[0:2] (operating_mode_o == 2'h0
            && !result_ready_n_o)) else $error("calibration end wrong");
endmodule : sdc_setup_control_mon

bind sdc_setup_control sdc_setup_control_mon i_mon (.core_clk_i, .sys_rst_i,
    .result_ready_n_o, .operating_mode_o, .calibrating_o, .clk_range_o, .update_rate_o,
    .unipolar_o, .buffer_en_o, .filter_hold_o, .word_stb_o, .filter_settled_o,
    .cutoff_mhz_o);

// ==== dv/sdc_host_model.sv ====
`timescale 1ns/1ps

module sdc_host_model (
    input  wire logic core_clk_i,
    input  wire logic dout_i,
    output logic      sclk_o,
    output logic      din_o,
    output logic      cs_n_o
);
    // ***************************************************
    // four-wire host, serial clock parked high
    // ***************************************************
    initial begin
        sclk_o = 1'b1;
        din_o  = 1'b0;
        cs_n_o = 1'b1;
    end

    task automatic sel(input logic on);
        repeat (6) @(posedge core_clk_i);
        #1 cs_n_o = ~on;
    endtask : sel

    // six-cycle half periods clear the pin filter with margin
    task automatic shift(input logic [15:0] v, input int nb, output logic [15:0] r);
        r = 16'h0000;
        for (int i = nb - 1; i >= 0; i--) begin
            repeat (6) @(posedge core_clk_i);
            #1 sclk_o = 1'b0;
            din_o = v[i];
            repeat (6) @(posedge core_clk_i);
            r = {r[14:0], dout_i};
            #1 sclk_o = 1'b1;
        end
        repeat (6) @(posedge core_clk_i);
        #1 din_o = ~din_o; // released line must not keep the last bit
    endtask : shift
endmodule : sdc_host_model

// ==== dv/sdc_setup_control_test.sv ====
`timescale 1ns/1ps

module sdc_setup_control_test;
    localparam int CORE_HZ    = 5000;
    localparam int RT [8]     = '{20, 25, 100, 200, 50, 60, 250, 500};
    logic          core_clk_i = 1'b0;
    logic          sys_rst_i  = 1'b1;
    logic          sclk, din, cs_n, dout, ready_n, calibrating, clk_range;
    logic          unipolar, buffer_en, hold, stb, settled, standby;
    logic [1:0]    mode, rate, gain;
    logic [15:0]   result_word = 16'hA5C3;
    logic [17:0]   cutoff;
    int            n_mismatch = 0;
    int            n_checks   = 0;

    always #10 core_clk_i = ~core_clk_i;

    sdc_setup_control #(.CORE_HZ(CORE_HZ), .SELF_CAL_WORDS(40), .SYS_CAL_WORDS(30)) i_dut (
        .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .sclk_i(sclk), .din_i(din),
        .cs_n_i(cs_n), .result_word_i(result_word), .dout_o(dout), .result_ready_n_o(ready_n),
        .operating_mode_o(mode), .calibrating_o(calibrating), .clk_range_o(clk_range),
        .update_rate_o(rate), .unipolar_o(unipolar), .buffer_en_o(buffer_en),
        .filter_hold_o(hold), .word_stb_o(stb), .filter_settled_o(settled),
        .cutoff_mhz_o(cutoff), .standby_o(standby), .gain_o(gain));

    sdc_host_model i_host (.core_clk_i(core_clk_i), .dout_i(dout), .sclk_o(sclk),
        .din_o(din), .cs_n_o(cs_n));

    // ***************************************************
    // shared tasks
    // ***************************************************
    task automatic check(input logic [17:0] seen, input logic [17:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] v);
        logic [15:0] r;
        i_host.shift(16'h0010, 8, r);
        i_host.shift({8'h00, v}, 8, r);
        repeat (6) @(posedge core_clk_i);
    endtask : wr

    task automatic rd(output logic [7:0] v);
        logic [15:0] r;
        i_host.shift(16'h0018, 8, r);
        i_host.shift(16'h0000, 8, r);
        v = r[7:0];
    endtask : rd

    task automatic wait_stb(output int cyc);
        cyc = 0;
        do begin
            @(posedge core_clk_i);
            cyc++;
        end while (stb !== 1'b1 && cyc < 3000);
    endtask : wait_stb

    function automatic logic [17:0] fields();
        return 18'({mode, clk_range, rate, unipolar, buffer_en, hold});
    endfunction : fields

    // ***************************************************
    // scenarios
    // ***************************************************
    task automatic t_reset();
        logic [7:0]  v;
        logic [15:0] r;
        check(fields(), 18'h00028);
        rd(v);
        check(18'(v), 18'h00028);
        i_host.shift(16'h003B, 8, r);
        check(18'({standby, gain}), 18'h00003);
        i_host.shift(16'h0000, 16, r);
        check(18'(r), 18'(result_word));
        $display("test reset done");
    endtask : t_reset

    task automatic t_fields();
        logic [15:0] r;
        logic [7:0]  v;
        int          c;
        i_host.shift(16'h0010, 8, r);
        i_host.shift(16'h001F, 7, r);
        i_host.sel(1'b0);
        check(fields(), 18'h00028);
        i_host.sel(1'b1);
        // a deselect keeps the access phase, so only the data byte follows
        i_host.shift(16'h003E, 8, r);
        repeat (6) @(posedge core_clk_i);
        check(fields(), 18'h0003E);
        rd(v);
        check(18'(v), 18'h0003E);
        wr(8'h3E);
        repeat (3) wait_stb(c);
        repeat (2) @(posedge core_clk_i);
        check(18'(settled), 18'h00000);
        wait_stb(c);
        repeat (2) @(posedge core_clk_i);
        check(18'(settled), 18'h00001);
        $display("test fields done");
    endtask : t_fields

    task automatic t_rates();
        int c;
        for (int i = 0; i < 8; i++) begin
            wr({2'b00, 3'(i), 3'b000});
            wait_stb(c);
            wait_stb(c);
            check(18'(c), 18'(CORE_HZ / RT[i]));
            check(cutoff, 18'(RT[i] * 262));
        end
        $display("test rates done");
    endtask : t_rates

    task automatic t_hold();
        logic [7:0] v;
        int         c;
        wr(8'h38);
        wait_stb(c);
        wr(8'h39);
        check(18'({hold, ready_n}), 18'h00002);
        rd(v);
        check(18'({v, ready_n}), 18'h00072);
        wr(8'h38);
        wait_stb(c);
        check(18'(c >= 24 && c <= 34), 18'h00001);
        repeat (2) @(posedge core_clk_i);
        check(18'(settled), 18'h00001);
        $display("test hold done");
    endtask : t_hold

    task automatic t_cal();
        logic [7:0] v;
        int         c;
        for (int m = 1; m < 4; m++) begin
            wr({2'(m), 6'h38});
            check(18'({calibrating, ready_n}), 18'h00003);
            rd(v);
            check(18'(v), 18'({2'(m), 6'h38}));
            c = 0;
            while (calibrating === 1'b1 && c < 3000) begin
                @(posedge core_clk_i);
                c++;
            end
            repeat (3) @(posedge core_clk_i);
            check(18'({mode, ready_n}), 18'h00000);
            rd(v);
            check(18'(v), 18'h00038);
        end
        $display("test calibration done");
    endtask : t_cal

    // ***************************************************
    // run control
    // ***************************************************
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up

    initial begin
        repeat (2) @(posedge core_clk_i);
        #1 sys_rst_i = 1'b0;
        i_host.sel(1'b1);
        t_reset();
        t_fields();
        t_rates();
        t_hold();
        t_cal();
        wrap_up();
    end

    initial begin
        repeat (40000) @(posedge core_clk_i);
        n_mismatch++;
        $display("BAD t=%0t watchdog expired", $time);
        wrap_up();
    end
endmodule : sdc_setup_control_test
